// ### core/rgd_decoder.sv
`timescale 1ns/1ps
module rgd_decoder
   import rgd_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   input wire logic [PIN_W-1:0] gpio_in,
   output logic [PIN_W-1:0] gpio_out,
   output logic [PIN_W-1:0] gpio_oe,
   input wire logic [1:0] clock_mode,
   output logic fifo_clear,
   output logic regs_default,
   output logic [7:0] setup_init,
   output logic [7:0] adc_reg_init,
   output logic slow_mode,
   output logic force_bias_on,
   output logic skip_wakeup,
   output logic [15:0] dac_word,
   output logic dac_word_valid,
   output logic dac_all_clear,
   output logic dac_all_fill
);

   // Pin inputs all cross into clk through two flops
   logic [SYNC_W-1:0] sync_q;

   rgd_sync u_sync (
      .clk(clk),
      .nrst(nrst),
      .async_in({~cs_n, sclk, din, gpio_in}),
      .sync_out(sync_q)
   );

   // Chip select crosses inverted so the cleared synchroniser reads idle, no false rise
   wire cs_n_s = ~sync_q[SYNC_W-1];
   wire sclk_s = sync_q[SYNC_W-2];
   wire din_s = sync_q[SYNC_W-3];
   wire [PIN_W-1:0] pins_s = sync_q[PIN_W-1:0];

   logic sclk_prev;
   logic cs_prev;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk_prev <= 1'b0;
         cs_prev <= 1'b1;
      end else begin
         sclk_prev <= sclk_s;
         cs_prev <= cs_n_s;
      end
   end

   // Edges only count inside a frame
   wire sclk_fall = sclk_prev & ~sclk_s & ~cs_n_s;
   wire sclk_rise = ~sclk_prev & sclk_s & ~cs_n_s;
   wire cs_rise = ~cs_prev & cs_n_s;

   rgd_state_t state;
   rgd_state_t next_state;
   logic [4:0] bit_cnt;
   logic [4:0] next_bit_cnt;
   logic [15:0] shreg;

   wire [15:0] next_shreg = {shreg[14:0], din_s};
   wire [7:0] cmd = next_shreg[7:0];

   // Command decode
   wire is_nop = (cmd == CMD_NOP);
   wire is_reset = (cmd[7:3] == CMD_RESET_SEL);
   wire is_gpio = (cmd[7:2] == CMD_GPIO_SEL);
   wire is_gpio_cfg = is_gpio && (cmd == CMD_GPIO_CFG);
   wire is_gpio_wr = is_gpio && (cmd == CMD_GPIO_WR);
   wire is_gpio_rd = is_gpio && (cmd == CMD_GPIO_RD);
   wire is_dac = (cmd[7:4] == CMD_DAC_SEL);

   wire in_byte_state = (state != ST_DAC);
   wire byte_done = sclk_fall && in_byte_state && (bit_cnt == CMD_LAST_BIT);
   wire dac_done = sclk_fall && (state == ST_DAC) && (bit_cnt == DAC_LAST_BIT);
   wire cmd_done = byte_done && (state == ST_CMD);

   // Reset-control write fields
   wire rst_full = cmd[RST_FULL_BIT];
   wire rst_slow = cmd[RST_SLOW_BIT];
   wire rst_fbg = cmd[RST_FBG_BIT];
   wire reset_write = cmd_done && is_reset;

   // DAC word fields
   wire [3:0] dac_ctrl = next_shreg[DAC_CTRL_HI:DAC_CTRL_LO];
   wire dac_fill_sel = next_shreg[DAC_FIRST_DATA_BIT];
   wire dac_clear_cmd = dac_done && (dac_ctrl == DAC_CTRL_CLEAR);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_CMD: begin
            if (cmd_done) begin
               if (is_gpio_cfg) begin
                  next_state = ST_CFG;
               end else if (is_gpio_wr) begin
                  next_state = ST_WR;
               end else if (is_gpio_rd) begin
                  next_state = ST_RD;
               end else if (is_dac) begin
                  next_state = ST_DAC;
               end else begin
                  // Nop and one-byte foreign commands stay here
                  next_state = ST_CMD;
               end
            end
         end
         ST_CFG, ST_WR, ST_RD: begin
            if (byte_done) begin
               next_state = ST_CMD;
            end
         end
         ST_DAC: begin
            if (dac_done) begin
               next_state = ST_CMD;
            end
         end
         default: next_state = ST_CMD;
      endcase
      // Chip select high aborts any partial transfer
      if (cs_n_s) begin
         next_state = ST_CMD;
      end
   end

   always_comb begin
      next_bit_cnt = bit_cnt;
      if (cs_n_s) begin
         next_bit_cnt = 5'h00;
      end else if (byte_done || dac_done) begin
         next_bit_cnt = 5'h00;
      end else if (sclk_fall) begin
         next_bit_cnt = bit_cnt + 5'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_CMD;
         bit_cnt <= 5'h00;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shreg <= 16'h0000;
      end else if (sclk_fall) begin
         shreg <= next_shreg;
      end
   end

   // Reset control register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slow_mode <= RESET_CTRL_RESET[RST_SLOW_BIT];
         force_bias_on <= RESET_CTRL_RESET[RST_FBG_BIT];
      end else if (reset_write) begin
         slow_mode <= rst_slow;
         force_bias_on <= rst_fbg;
      end
   end

   // Every reset write empties the FIFO; power-on state implies empty too
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fifo_clear <= 1'b0;
         regs_default <= 1'b0;
      end else begin
         fifo_clear <= reset_write && (!rst_full || rst_full || rst_slow || rst_fbg);
         regs_default <= reset_write && rst_full;
      end
   end

   // Power-on images the ADC register bank loads on regs_default
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setup_init <= SETUP_RESET;
         adc_reg_init <= ADC_REG_RESET;
      end else if (regs_default) begin
         setup_init <= SETUP_RESET;
         adc_reg_init <= ADC_REG_RESET;
      end
   end

   // Bias stays up, so the wake-up wait is pointless
   wire wake_mode = (clock_mode == CKMODE_01) || (clock_mode == CKMODE_11);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         skip_wakeup <= 1'b0;
      end else begin
         skip_wakeup <= force_bias_on && wake_mode;
      end
   end

   // GPIO staging; reset writes never touch these
   logic [PIN_W-1:0] cfg_stage;
   logic [PIN_W-1:0] wr_stage;
   logic cfg_pend;
   logic wr_pend;
   logic [PIN_W-1:0] gpio_cfg;
   logic [PIN_W-1:0] gpio_wr;

   wire [PIN_W-1:0] gpio_field = next_shreg[GPIO_FIELD_HI:GPIO_FIELD_LO];
   wire cfg_load = byte_done && (state == ST_CFG);
   wire wr_load = byte_done && (state == ST_WR);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_stage <= GPIO_CFG_RESET;
         cfg_pend <= 1'b0;
      end else if (cfg_load) begin
         cfg_stage <= gpio_field;
         cfg_pend <= 1'b1;
      end else if (cs_rise) begin
         cfg_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_stage <= GPIO_WR_RESET;
         wr_pend <= 1'b0;
      end else if (wr_load) begin
         wr_stage <= gpio_field;
         wr_pend <= 1'b1;
      end else if (cs_rise) begin
         wr_pend <= 1'b0;
      end
   end

   // Pins change only once the frame closes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpio_cfg <= GPIO_CFG_RESET;
         gpio_wr <= GPIO_WR_RESET;
      end else if (cs_rise) begin
         if (cfg_pend) begin
            gpio_cfg <= cfg_stage;
         end
         if (wr_pend) begin
            gpio_wr <= wr_stage;
         end
      end
   end

   // 11 high, 10 low, 01 released, 00 pulled low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpio_out <= 4'h0;
         gpio_oe <= 4'h0;
      end else begin
         gpio_out <= gpio_cfg & gpio_wr;
         gpio_oe <= gpio_cfg | ~gpio_wr;
      end
   end

   // GPIO read: snapshot at command end, pins in the last four slots
   logic [7:0] rd_sh;
   logic dout_raw;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_sh <= 8'h00;
      end else if (cmd_done && is_gpio_rd) begin
         rd_sh <= {GPIO_RD_PAD, pins_s};
      end else if (sclk_rise && (state == ST_RD)) begin
         rd_sh <= {rd_sh[6:0], 1'b0};
      end
   end

   // Output moves on rising edges so the host can take it on falling ones
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dout_raw <= 1'b0;
      end else if (cs_n_s) begin
         dout_raw <= 1'b0;
      end else if (sclk_rise) begin
         dout_raw <= (state == ST_RD) ? rd_sh[7] : 1'b0;
      end
   end

   // Slow path adds whole cycles of delay; costs latency, gains hold
   logic [SLOW_DELAY_CYC-1:0] dout_dly;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dout_dly <= '0;
         dout <= 1'b0;
      end else begin
         dout_dly <= {dout_dly[SLOW_DELAY_CYC-2:0], dout_raw};
         dout <= slow_mode ? dout_dly[SLOW_DELAY_CYC-1] : dout_raw;
      end
   end

   // DAC word hand-off; a short frame never reaches dac_done
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac_word <= DAC_WORD_RESET;
      end else if (dac_done) begin
         dac_word <= next_shreg;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac_word_valid <= 1'b0;
         dac_all_clear <= 1'b0;
         dac_all_fill <= 1'b0;
      end else begin
         dac_word_valid <= dac_done;
         dac_all_clear <= dac_clear_cmd && !dac_fill_sel;
         dac_all_fill <= dac_clear_cmd && dac_fill_sel;
      end
   end

endmodule : rgd_decoder

// ### core/rgd_pkg.sv
package rgd_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLOW_DELAY_NS = 15;
   // Least delay, so round up to whole cycles
   localparam int SLOW_DELAY_CYC = (SLOW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Last serial clock cycle of each command byte and of the DAC word, counted from zero
   localparam logic [4:0] CMD_LAST_BIT = 5'h07;
   localparam logic [4:0] DAC_LAST_BIT = 5'h0F;

   // Synchroniser lanes: cs_n, sclk, din, four pins
   localparam int SYNC_W = 7;
   localparam int PIN_W = 4;

   // Command decode
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [4:0] CMD_RESET_SEL = 5'h01;
   localparam logic [5:0] CMD_GPIO_SEL = 6'h00;
   localparam logic [3:0] CMD_DAC_SEL = 4'h1;
   localparam logic [7:0] CMD_GPIO_CFG = 8'h03;
   localparam logic [7:0] CMD_GPIO_WR = 8'h02;
   localparam logic [7:0] CMD_GPIO_RD = 8'h01;

   // Reset control fields
   localparam int RST_FULL_BIT = 2;
   localparam int RST_SLOW_BIT = 1;
   localparam int RST_FBG_BIT = 0;
   localparam logic [7:0] RESET_CTRL_RESET = 8'h00;

   // Setup register power-on image: clock_mode_hi and reference_mode_hi set
   localparam int SETUP_CLOCK_MODE_HI_BIT = 5;
   localparam int SETUP_REFERENCE_MODE_HI_BIT = 3;
   localparam logic [7:0] SETUP_RESET = 8'h28;
   localparam logic [7:0] ADC_REG_RESET = 8'h00;

   // Clock modes that carry a wake-up delay
   localparam logic [1:0] CKMODE_01 = 2'b01;
   localparam logic [1:0] CKMODE_11 = 2'b11;

   // GPIO data byte: pins in the top nibble, C1 C0 A1 A0
   localparam int GPIO_FIELD_HI = 7;
   localparam int GPIO_FIELD_LO = 4;
   localparam logic [3:0] GPIO_CFG_RESET = 4'h0;
   localparam logic [3:0] GPIO_WR_RESET = 4'hF;
   localparam logic [3:0] GPIO_RD_PAD = 4'h0;

   // DAC word layout
   localparam int DAC_CTRL_HI = 15;
   localparam int DAC_CTRL_LO = 12;
   localparam int DAC_FIRST_DATA_BIT = 11;
   localparam logic [3:0] DAC_CTRL_CLEAR = 4'h1;
   localparam logic [15:0] DAC_WORD_RESET = 16'h0000;

   typedef enum logic [4:0] {
      ST_CMD = 5'b00001,
      ST_CFG = 5'b00010,
      ST_WR = 5'b00100,
      ST_RD = 5'b01000,
      ST_DAC = 5'b10000
   } rgd_state_t;

endpackage : rgd_pkg

// ### core/rgd_sync.sv
`timescale 1ns/1ps
module rgd_sync
   import rgd_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [SYNC_W-1:0] async_in,
   output logic [SYNC_W-1:0] sync_out
);

   logic [SYNC_W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : rgd_sync

// ### sim/rgd_chk.sv
`timescale 1ns/1ps
module rgd_chk
   import rgd_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic [1:0] clock_mode,
   input wire logic fifo_clear,
   input wire logic regs_default,
   input wire logic [7:0] setup_init,
   input wire logic [7:0] adc_reg_init,
   input wire logic slow_mode,
   input wire logic force_bias_on,
   input wire logic skip_wakeup,
   input wire logic [PIN_W-1:0] gpio_out,
   input wire logic [PIN_W-1:0] gpio_oe,
   input wire logic [15:0] dac_word,
   input wire logic dac_word_valid,
   input wire logic dac_all_clear,
   input wire logic dac_all_fill
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_IMAGES: assert property (setup_init == 8'h28 && adc_reg_init == 8'h00)
      else $error("power-on images wrong");
   AST_FIFO_PULSE: assert property (fifo_clear |=> !fifo_clear)
      else $error("fifo clear longer than one cycle");
   AST_FULL_CLEARS: assert property (regs_default |-> fifo_clear)
      else $error("full reset without fifo clear");
   AST_SLOW_CLEARS: assert property ($rose(slow_mode) |-> fifo_clear)
      else $error("slow set without fifo clear");
   AST_FBG_CLEARS: assert property ($rose(force_bias_on) |-> fifo_clear)
      else $error("force bias set without fifo clear");
   AST_SKIP: assert property (1'b1 |=> skip_wakeup == $past(force_bias_on && clock_mode[0]))
      else $error("skip wakeup wrong");
   AST_GPIO_COMMIT: assert property ($changed({gpio_oe, gpio_out}) |-> cs_n && $past(cs_n))
      else $error("pins changed inside a frame");
   AST_DAC_HOLD: assert property ($changed(dac_word) |-> dac_word_valid)
      else $error("dac word changed without a full word");
   AST_VALID_PULSE: assert property (dac_word_valid |=> !dac_word_valid)
      else $error("dac valid longer than one cycle");
   AST_DAC_CLEAR: assert property (dac_all_clear |-> dac_word[15:12] == 4'h1 && !dac_word[11])
      else $error("dac clear on wrong word");
   AST_DAC_FILL: assert property (dac_all_fill |-> dac_word[15:12] == 4'h1 && dac_word[11])
      else $error("dac fill on wrong word");
   cover property (regs_default);
   cover property (dac_all_fill);
   cover property (skip_wakeup);
endmodule : rgd_chk
bind rgd_decoder rgd_chk i_chk (.clk(clk), .nrst(nrst), .cs_n(cs_n), .clock_mode(clock_mode),
   .fifo_clear(fifo_clear), .regs_default(regs_default), .setup_init(setup_init),
   .adc_reg_init(adc_reg_init), .slow_mode(slow_mode), .force_bias_on(force_bias_on),
   .skip_wakeup(skip_wakeup), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .dac_word(dac_word),
   .dac_word_valid(dac_word_valid), .dac_all_clear(dac_all_clear), .dac_all_fill(dac_all_fill));

// ### sim/rgd_host.sv
`timescale 1ns/1ps
module rgd_host (
   input wire logic clk,
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // Clock stands low between frames
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
      rx = 32'h0000_0000;
      // Start just after a clk edge so no link edge ever lands on one
      @(posedge clk);
      #1;
      cs_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         din = tx[i];
         #62.5;
         rx[i] = dout;
         sclk = 1'b0;
         #62.5;
      end
      #100;
      cs_n = 1'b1;
      // Released line shows the inverse, not a stale bit
      din = ~din;
      #300;
   endtask : xfer
endmodule : rgd_host

// ### sim/tb_reset_gpio_dac_select_decoder.sv
`timescale 1ns/1ps
module tb_reset_gpio_dac_select_decoder
   import rgd_pkg::*;
;
   logic clk, nrst, cs_n, sclk, din, dout;
   logic [PIN_W-1:0] gpio_in, gpio_out, gpio_oe, ext;
   logic [1:0] clock_mode;
   logic fifo_clear, regs_default, slow_mode, force_bias_on, skip_wakeup;
   logic [7:0] setup_init, adc_reg_init;
   logic [15:0] dac_word;
   logic [15:0] words [3];
   logic dac_word_valid, dac_all_clear, dac_all_fill;
   logic [31:0] rx;
   int err_count = 0;
   int samples_checked = 0;
   int n_fc = 0;
   int n_rd = 0;
   int n_dv = 0;
   int n_cl = 0;
   int n_fl = 0;
   // Pin level: our drive, else the outside level
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext);
   rgd_decoder i_dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .clock_mode(clock_mode),
      .fifo_clear(fifo_clear), .regs_default(regs_default), .setup_init(setup_init),
      .adc_reg_init(adc_reg_init), .slow_mode(slow_mode), .force_bias_on(force_bias_on),
      .skip_wakeup(skip_wakeup), .dac_word(dac_word), .dac_word_valid(dac_word_valid),
      .dac_all_clear(dac_all_clear), .dac_all_fill(dac_all_fill));
   rgd_host i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      n_fc <= n_fc + int'(fifo_clear === 1'b1);
      n_rd <= n_rd + int'(regs_default === 1'b1);
      n_dv <= n_dv + int'(dac_word_valid === 1'b1);
      n_cl <= n_cl + int'(dac_all_clear === 1'b1);
      n_fl <= n_fl + int'(dac_all_fill === 1'b1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      print_verdict();
   end
   initial begin
      nrst = 1'b0;
      clock_mode = 2'b00;
      ext = 4'h0;
      words = '{16'hABCD, 16'h1800, 16'h1000};
      repeat (5) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge clk);
      chk({gpio_oe, slow_mode, force_bias_on}, 6'h00);
      chk({setup_init, adc_reg_init}, 16'h2800);
      i_host.xfer(8, 32'h0000_000F, rx);
      chk({slow_mode, force_bias_on, n_fc[3:0], n_rd[3:0]}, 10'h311);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         #1 clock_mode = m[1:0];
         repeat (3) @(posedge clk);
         chk(skip_wakeup, m[0]);
      end
      i_host.xfer(8, 32'h0000_0008, rx);
      chk({slow_mode, force_bias_on, n_fc[3:0], n_rd[3:0]}, 10'h021);
      i_host.xfer(8, 32'h0000_000A, rx);
      chk({slow_mode, force_bias_on, n_fc[3:0]}, 6'h23);
      // Config then write in one frame, C1 high, C0 low, A1 input, A0 pulldown
      i_host.xfer(32, 32'h03C0_02A0, rx);
      chk(rx, 32'h0000_0000);
      chk({gpio_oe, gpio_out & gpio_oe}, 8'hD8);
      // Slow output path still meets the host sample point
      for (int e = 0; e < 4; e += 2) begin
         ext = e[3:0];
         i_host.xfer(24, 32'h0000_0100, rx);
         chk(rx, {28'h000_0000, 2'b10, ext[1], 1'b0});
      end
      for (int w = 0; w < 3; w++) begin
         i_host.xfer(24, {8'h00, 8'h10, words[w]}, rx);
         chk(dac_word, words[w]);
      end
      chk({n_dv[3:0], n_cl[3:0], n_fl[3:0]}, 12'h311);
      i_host.xfer(18, {14'h0000, 8'h10, 10'h3FF}, rx);
      chk({dac_word, n_dv[3:0]}, 20'h1000_3);
      i_host.xfer(8, 32'h0000_000C, rx);
      chk({dac_word, gpio_oe, n_rd[3:0], slow_mode}, 25'h020_01A4);
      i_host.xfer(8, 32'h0000_0009, rx);
      chk({force_bias_on, n_fc[3:0]}, 5'h15);
      print_verdict();
   end
endmodule : tb_reset_gpio_dac_select_decoder
